// ### pm_cfg.svh
`ifndef PM_CFG_SVH
`define PM_CFG_SVH

// Result and byte widths
`define PM_CODE_W       12
`define PM_BYTE_W       8
`define PM_ADDR_W       7
`define PM_NIB_W        4

// Status byte bit positions
`define PM_ST_ADC_RECENT 0
`define PM_ST_ADC_ALERT  1
`define PM_ST_COMP_LIVE  2
`define PM_ST_COMP_LATCH 3
`define PM_ST_REL_STATUS 4
`define PM_ST_REL_ALERT  5

// Serial framing constants
`define PM_DIR_READ     1'h1
`define PM_BIT_LAST     3'h7
`define PM_BIT_FIRST    3'h0
`define PM_IDX_FIRST    2'h0
`define PM_IDX_ONE      2'h1
`define PM_IDX_TWO      2'h2
`define PM_NIB_ZERO     4'h0
`define PM_BYTE_ONES    8'hff
`define PM_BYTE_ZERO    8'h00
`define PM_CODE_ZERO    12'h000
`define PM_CNT_STATUS   2'h1
`define PM_CNT_SINGLE   2'h2
`define PM_CNT_BOTH     2'h3

// Reset values
`define PM_THRESH_RST   8'hff
`define PM_EN_RST       5'h00
`define PM_HIST_RST     3'h0

`endif

// ### pm_pkg.sv
package pm_pkg;
  `include "pm_cfg.svh"

  // Command byte fields that steer readback
  typedef struct packed {
    logic status_sel;
    logic cur_once;
    logic cur_rep;
    logic volt_once;
    logic volt_repeat_mode;
  } pm_cmd_t;

  // Alert enable register, bit 4 down to bit 0
  typedef struct packed {
    logic clear_latches;
    logic en_release;
    logic en_comp_alert;
    logic en_adc4;
    logic en_adc1;
  } pm_alert_en_t;

  typedef enum logic [2:0] {
    PM_IDLE,
    PM_ADDR,
    PM_ADDR_ACK,
    PM_LOAD,
    PM_TX,
    PM_MACK,
    PM_WAIT_STOP
  } pm_state_t;

  // Serial slave state
  typedef struct packed {
    pm_state_t                  state;
    logic [`PM_BYTE_W-1:0]      shift;
    logic [2:0]                 bit_cnt;
    logic [1:0]                 byte_idx;
    logic                       scl_q;
    logic                       sda_q;
    logic                       sda_oe;
    logic                       pin_lo;
    pm_cmd_t                    cmd;
    logic [`PM_CODE_W-1:0]      volt;
    logic [`PM_CODE_W-1:0]      cur;
    logic                       volt_seen;
    logic                       cur_seen;
    logic                       once_pend;
  } pm_top_st_t;

  // Status and alert state
  typedef struct packed {
    logic [2:0]                 hist;
    logic                       adc_alert;
    logic                       comp_latched;
    logic                       rel_status;
    logic                       rel_alert;
    pm_alert_en_t               en;
    logic [`PM_BYTE_W-1:0]      thresh;
    logic [`PM_BYTE_W-1:0]      status;
    logic                       alert_oe;
    logic                       pin_lo;
  } pm_stat_st_t;
endpackage

// ### pm_sync.sv
`timescale 1ns/1ps
// Two flop synchroniser, one lane per bit
module pm_sync #(
  parameter int W = 1
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_lane
      // First flop feeds only the second
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_reg[g] <= 1'b0;
          o_sync[g]   <= 1'b0;
        end else begin
          meta_reg[g] <= i_async[g];
          o_sync[g]   <= meta_reg[g];
        end
      end
    end
  endgenerate
endmodule

// ### pm_status.sv
`timescale 1ns/1ps
`include "pm_cfg.svh"
// Status byte, overcurrent latches and alert pin drive
module pm_status
  import pm_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_conv_valid,
  input  wire logic [`PM_BYTE_W-1:0] i_cur_msb,
  input  wire logic                  i_comp_live,
  input  wire logic                  i_alert_en_wr,
  input  wire pm_alert_en_t          i_alert_en,
  input  wire logic                  i_thresh_wr,
  input  wire logic [`PM_BYTE_W-1:0] i_thresh,
  input  wire logic                  i_release_wr,
  input  wire logic                  i_release_val,
  output logic [`PM_BYTE_W-1:0]      o_status,
  output logic                       o_clear_pending,
  output logic                       o_alert_oe,
  output logic                       o_alert_out
);
  pm_stat_st_t st_reg;
  pm_stat_st_t st_next;
  logic        over;
  logic        clr;

  // Next state of latches and alert
  always_comb begin
    st_next = st_reg;
    over    = i_conv_valid && (i_cur_msb > st_reg.thresh);
    clr     = st_reg.en.clear_latches;
    st_next.en.clear_latches = 1'b0;
    if (i_alert_en_wr) begin
      st_next.en = i_alert_en;
    end
    if (i_thresh_wr) begin
      st_next.thresh = i_thresh;
    end
    if (i_conv_valid) begin
      st_next.hist = {st_reg.hist[1:0], over};
    end
    if (clr) begin
      st_next.adc_alert    = 1'b0;
      st_next.comp_latched = 1'b0;
      st_next.rel_alert    = 1'b0;
    end
    if (over && (st_reg.en.en_adc1 ||
                 (st_reg.en.en_adc4 && (&st_reg.hist)))) begin
      st_next.adc_alert = 1'b1;
    end
    if (i_comp_live && st_reg.en.en_comp_alert) begin
      st_next.comp_latched = 1'b1;
    end
    if (i_release_wr) begin
      st_next.rel_status = i_release_val;
    end
    if (i_release_wr && i_release_val && st_reg.en.en_release) begin
      st_next.rel_alert = 1'b1;
    end
    st_next.status = `PM_BYTE_ZERO;
    st_next.status[`PM_ST_ADC_RECENT] = &st_next.hist;
    st_next.status[`PM_ST_ADC_ALERT]  = st_next.adc_alert;
    st_next.status[`PM_ST_COMP_LIVE]  = i_comp_live;
    st_next.status[`PM_ST_COMP_LATCH] = st_next.comp_latched;
    st_next.status[`PM_ST_REL_STATUS] = st_next.rel_status;
    st_next.status[`PM_ST_REL_ALERT]  = st_next.rel_alert;
    // open-drain low on a fault, same edge as latch
    st_next.alert_oe = st_next.adc_alert || st_next.comp_latched ||
                       st_next.rel_alert;
    st_next.pin_lo   = 1'b0;
  end

  // enables reset off, so alert stays released
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg        <= '0;
      st_reg.en     <= `PM_EN_RST;
      st_reg.thresh <= `PM_THRESH_RST;
      st_reg.hist   <= `PM_HIST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_status        = st_reg.status;
  assign o_clear_pending = st_reg.en.clear_latches;
  assign o_alert_oe      = st_reg.alert_oe;
  assign o_alert_out     = st_reg.pin_lo;
endmodule

// ### pm_readback.sv
// Behaviour
// - Both channels: volt MSBs, current MSBs, then volt and current nibbles.
// - Voltage only: volt MSBs, then volt low nibble over zero nibble.
// - Current only: current MSBs, then current low nibble over zero.
// - Read begins with start, address, read bit; slave acks first.
// - Single-channel readback is two data bytes long.
// - Status read is start, address, ack, one status byte, master ack.
// - Status bit 0: ADC overcurrent seen on last three conversions.
// - Status bit 1 latches an ADC trip alert until cleared.
// - Status bit 2 shows the live comparator result.
// - Status bit 3 latches comparator fault; alert asserts together.
// - Status bit 4 set by writing the software release bit.
// - Status bit 5 latches an alert caused by software release.
// - Bits 1, 3, 5 cleared only by the clear-latches bit.
// - Alert pin is open-drain active low, pulled low on overcurrent.
// - Alert stays disabled after power-up until enabled.
// - Comparator asserts when sense output exceeds threshold input.
// - Each result is an unsigned 12-bit code.
// - Continuous mode: read before first conversion acks, returns zeros.
// - Single mode: nack reads until conversion done; request self-clears.
// - Status-select in command makes reads return the status byte.
// - Clear-latches self-clears; a persisting cause sets again at once.
`timescale 1ns/1ps
`include "pm_cfg.svh"
module pm_readback
  import pm_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_scl,
  input  wire logic                   i_sda_in,
  input  wire logic [`PM_ADDR_W-1:0]  i_dev_addr,
  input  wire logic                   i_trip_threshold_input,
  input  wire logic                   i_cmd_wr,
  input  wire pm_cmd_t                i_cmd,
  input  wire logic                   i_conv_valid,
  input  wire logic [`PM_CODE_W-1:0]  i_volt_code,
  input  wire logic [`PM_CODE_W-1:0]  i_cur_code,
  input  wire logic                   i_alert_en_wr,
  input  wire pm_alert_en_t           i_alert_en,
  input  wire logic                   i_thresh_wr,
  input  wire logic [`PM_BYTE_W-1:0]  i_thresh,
  input  wire logic                   i_release_wr,
  input  wire logic                   i_release_val,
  output logic                        o_sda_out,
  output logic                        o_sda_oe,
  output logic                        o_alert_out,
  output logic                        o_alert_oe,
  output logic                        o_once_pending,
  output logic                        o_clear_pending,
  output logic [`PM_BYTE_W-1:0]       o_status
);
  localparam int SYNC_W = `PM_ADDR_W + 3;

  pm_top_st_t              st_reg;
  pm_top_st_t              st_next;
  logic [SYNC_W-1:0]       sync_out;
  logic                    s_scl;
  logic                    s_sda;
  logic                    s_comp;
  logic [`PM_ADDR_W-1:0]   s_addr;
  logic [`PM_BYTE_W-1:0]   status_byte;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_seen;
  logic                    stop_seen;
  logic                    volt_en;
  logic                    cur_en;
  logic [1:0]              byte_cnt;
  logic [`PM_BYTE_W-1:0]   addr_byte;
  logic [1:0]              next_idx;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and status block

  pm_sync #(
    .W (SYNC_W)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    ({i_dev_addr, i_trip_threshold_input, i_sda_in, i_scl}),
    .o_sync     (sync_out)
  );

  // Synchronised pin views
  assign s_scl  = sync_out[0];
  assign s_sda  = sync_out[1];
  assign s_comp = sync_out[2];
  assign s_addr = sync_out[SYNC_W-1:3];

  pm_status u_status (
    .i_core_clk      (i_core_clk),
    .i_rst_n         (i_rst_n),
    .i_conv_valid    (i_conv_valid),
    .i_cur_msb       (i_cur_code[`PM_CODE_W-1:`PM_NIB_W]),
    .i_comp_live     (s_comp),
    .i_alert_en_wr   (i_alert_en_wr),
    .i_alert_en      (i_alert_en),
    .i_thresh_wr     (i_thresh_wr),
    .i_thresh        (i_thresh),
    .i_release_wr    (i_release_wr),
    .i_release_val   (i_release_val),
    .o_status        (status_byte),
    .o_clear_pending (o_clear_pending),
    .o_alert_oe      (o_alert_oe),
    .o_alert_out     (o_alert_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // Readback byte selection

  // Byte for a given position of the read
  function automatic logic [`PM_BYTE_W-1:0] pick_byte(
    input logic [1:0]            idx,
    input pm_cmd_t               cmd,
    input logic [`PM_CODE_W-1:0] v,
    input logic [`PM_CODE_W-1:0] c,
    input logic [`PM_BYTE_W-1:0] stat
  );
    logic ve;
    logic ce;
    logic [`PM_BYTE_W-1:0] b;
    ve = cmd.volt_repeat_mode || cmd.volt_once;
    ce = cmd.cur_rep || cmd.cur_once;
    b  = `PM_BYTE_ONES;
    if (cmd.status_sel) begin
      if (idx == `PM_IDX_FIRST) begin
        b = stat;
      end
    end else if (ve && ce) begin
      case (idx)
        `PM_IDX_FIRST: b = v[`PM_CODE_W-1:`PM_NIB_W];
        `PM_IDX_ONE:   b = c[`PM_CODE_W-1:`PM_NIB_W];
        `PM_IDX_TWO:   b = {v[`PM_NIB_W-1:0], c[`PM_NIB_W-1:0]};
        default:       b = `PM_BYTE_ONES;
      endcase
    end else if (ve) begin
      case (idx)
        `PM_IDX_FIRST: b = v[`PM_CODE_W-1:`PM_NIB_W];
        `PM_IDX_ONE:   b = {v[`PM_NIB_W-1:0], `PM_NIB_ZERO};
        default:       b = `PM_BYTE_ONES;
      endcase
    end else begin
      case (idx)
        `PM_IDX_FIRST: b = c[`PM_CODE_W-1:`PM_NIB_W];
        `PM_IDX_ONE:   b = {c[`PM_NIB_W-1:0], `PM_NIB_ZERO};
        default:       b = `PM_BYTE_ONES;
      endcase
    end
    return b;
  endfunction

  // Channel enables and planned byte count
  assign volt_en = st_reg.cmd.volt_repeat_mode || st_reg.cmd.volt_once;
  assign cur_en  = st_reg.cmd.cur_rep || st_reg.cmd.cur_once;
  assign byte_cnt = st_reg.cmd.status_sel ? `PM_CNT_STATUS :
                    (volt_en && cur_en)   ? `PM_CNT_BOTH : `PM_CNT_SINGLE;

  // Bus edges and conditions
  assign scl_rise   = s_scl && !st_reg.scl_q;
  assign scl_fall   = !s_scl && st_reg.scl_q;
  assign start_seen = s_scl && st_reg.scl_q && st_reg.sda_q && !s_sda;
  assign stop_seen  = s_scl && st_reg.scl_q && !st_reg.sda_q && s_sda;
  assign addr_byte  = {st_reg.shift[`PM_BYTE_W-2:0], s_sda};
  assign next_idx   = st_reg.byte_idx + `PM_IDX_ONE;

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next        = st_reg;
    st_next.scl_q  = s_scl;
    st_next.sda_q  = s_sda;
    st_next.pin_lo = 1'b0;

    if (i_cmd_wr) begin
      st_next.cmd       = i_cmd;
      st_next.volt_seen = 1'b0;
      st_next.cur_seen  = 1'b0;
      st_next.once_pend = i_cmd.volt_once || i_cmd.cur_once;
    end
    if (i_conv_valid) begin
      if (volt_en) begin
        st_next.volt      = i_volt_code;
        st_next.volt_seen = 1'b1;
      end
      if (cur_en) begin
        st_next.cur      = i_cur_code;
        st_next.cur_seen = 1'b1;
      end
      st_next.once_pend        = 1'b0;
      st_next.cmd.volt_once    = 1'b0;
      st_next.cmd.cur_once     = 1'b0;
      st_next.cmd.volt_repeat_mode = st_reg.cmd.volt_repeat_mode ||
                                     st_reg.cmd.volt_once;
      st_next.cmd.cur_rep      = st_reg.cmd.cur_rep || st_reg.cmd.cur_once;
    end

    case (st_reg.state)
      PM_IDLE: begin
        st_next.sda_oe = 1'b0;
      end
      PM_ADDR: begin
        if (scl_rise) begin
          st_next.shift   = addr_byte;
          st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
          if (st_reg.bit_cnt == `PM_BIT_LAST) begin
            if (addr_byte[`PM_BYTE_W-1:1] == s_addr &&
                addr_byte[0] == `PM_DIR_READ && !st_reg.once_pend) begin
              st_next.state    = PM_ADDR_ACK;
              st_next.byte_idx = `PM_IDX_FIRST;
              st_next.shift    = pick_byte(`PM_IDX_FIRST, st_reg.cmd,
                st_reg.volt_seen ? st_reg.volt : `PM_CODE_ZERO,
                st_reg.cur_seen ? st_reg.cur : `PM_CODE_ZERO, status_byte);
            end else begin
              st_next.state = PM_WAIT_STOP;
            end
          end
        end
      end
      // slave ack on the ninth clock
      PM_ADDR_ACK: begin
        if (scl_fall) begin
          st_next.sda_oe = 1'b1;
          st_next.state  = PM_LOAD;
        end
      end
      // Put first bit of a byte on the line
      PM_LOAD: begin
        if (scl_fall) begin
          st_next.sda_oe  = !st_reg.shift[`PM_BYTE_W-1];
          st_next.bit_cnt = `PM_BIT_FIRST;
          st_next.state   = PM_TX;
        end
      end
      // Shift data out on falling edges
      PM_TX: begin
        if (scl_fall) begin
          if (st_reg.bit_cnt == `PM_BIT_LAST) begin
            st_next.sda_oe = 1'b0;
            st_next.state  = PM_MACK;
          end else begin
            st_next.shift   = {st_reg.shift[`PM_BYTE_W-2:0], 1'b0};
            st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            st_next.sda_oe  = !st_reg.shift[`PM_BYTE_W-2];
          end
        end
      end
      PM_MACK: begin
        if (scl_rise) begin
          if (!s_sda) begin
            st_next.byte_idx = next_idx;
            // bytes past the plan read as ones
            st_next.shift = (next_idx < byte_cnt) ?
              pick_byte(next_idx, st_reg.cmd,
                st_reg.volt_seen ? st_reg.volt : `PM_CODE_ZERO,
                st_reg.cur_seen ? st_reg.cur : `PM_CODE_ZERO, status_byte) :
              `PM_BYTE_ONES;
            st_next.state = PM_LOAD;
          end else begin
            st_next.state = PM_WAIT_STOP;
          end
        end
      end
      PM_WAIT_STOP: begin
        st_next.sda_oe = 1'b0;
      end
      default: begin
        st_next.state  = PM_IDLE;
        st_next.sda_oe = 1'b0;
      end
    endcase

    // Start and stop override any state
    if (start_seen) begin
      st_next.state   = PM_ADDR;
      st_next.bit_cnt = `PM_BIT_FIRST;
      st_next.sda_oe  = 1'b0;
    end else if (stop_seen) begin
      st_next.state  = PM_IDLE;
      st_next.sda_oe = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg       <= '0;
      st_reg.state <= PM_IDLE;
      st_reg.scl_q <= 1'b1;
      st_reg.sda_q <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign o_sda_out      = st_reg.pin_lo;
  assign o_sda_oe       = st_reg.sda_oe;
  assign o_once_pending = st_reg.once_pend;
  assign o_status       = status_byte;
endmodule

// ### pm_readback_monitor.sv
`timescale 1ns/1ps
// Port level checks beside the readback block
module pm_readback_monitor
  import pm_pkg::*;
(
  input wire logic         i_core_clk,
  input wire logic         i_rst_n,
  input wire logic         i_scl,
  input wire logic         i_trip_threshold_input,
  input wire logic         i_alert_en_wr,
  input wire pm_alert_en_t i_alert_en,
  input wire logic         i_release_wr,
  input wire logic         i_release_val,
  input wire logic         o_sda_out,
  input wire logic         o_sda_oe,
  input wire logic         o_alert_out,
  input wire logic         o_alert_oe,
  input wire logic         o_once_pending,
  input wire logic         o_clear_pending,
  input wire logic [7:0]   o_status
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////
  // Clear request and its one cycle echo
  sequence s_clr_req;
    i_alert_en_wr && i_alert_en.clear_latches;
  endsequence
  sequence s_clr_pulse;
    o_clear_pending ##1 !o_clear_pending;
  endsequence

  chk_clear_pulse: assert property (
    s_clr_req |=> s_clr_pulse) else $error("clear bit not a pulse");
  chk_latch_hold: assert property (
    $fell(o_status[1]) || $fell(o_status[3]) || $fell(o_status[5])
    |-> $past(o_clear_pending)) else $error("latch fell without clear");
  chk_live_rise: assert property (
    $rose(i_trip_threshold_input) |-> ##[1:5] o_status[2])
    else $error("live trip bit late");
  chk_alert_rise: assert property (
    $rose(o_status[3]) |-> ##[0:1] o_alert_oe)
    else $error("alert not with latched trip");
  chk_alert_fall: assert property (
    $fell(o_alert_oe) |-> ##[0:1]
    (!o_status[1] && !o_status[3] && !o_status[5]))
    else $error("alert released while latched");
  chk_release_set: assert property (
    i_release_wr && i_release_val |=> o_status[4])
    else $error("release status not set");
  chk_refuse_pending: assert property (
    o_once_pending && $past(o_once_pending) |-> !$rose(o_sda_oe))
    else $error("slave drove data while pending");
  chk_sda_scl_low: assert property (
    $changed(o_sda_oe) |-> !i_scl) else $error("data moved with clock high");
  chk_open_drain: assert property (
    !o_sda_out && !o_alert_out) else $error("open drain level not low");
endmodule

bind pm_readback pm_readback_monitor mon_u (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(i_scl),
  .i_trip_threshold_input(i_trip_threshold_input),
  .i_alert_en_wr(i_alert_en_wr), .i_alert_en(i_alert_en),
  .i_release_wr(i_release_wr), .i_release_val(i_release_val),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_alert_out(o_alert_out),
  .o_alert_oe(o_alert_oe), .o_once_pending(o_once_pending),
  .o_clear_pending(o_clear_pending), .o_status(o_status)
);

// ### pm_bus_master.sv
`timescale 1ns/1ps
// Serial bus master, clock driven high and low directly, data released open drain
module pm_bus_master (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_rel
);
  int half = 8;

  // Idle bus: both lines released
  initial begin
    o_scl = 1'b1;
    o_sda_rel = 1'b1;
  end

  ////////////////////////////////////////
  // Wait whole core cycles
  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // One clock pulse, data set while clock low, sampled at high end
  task automatic clk_bit(input logic b, output logic s);
    o_sda_rel <= b;
    wt(half);
    o_scl <= 1'b1;
    wt(half);
    s = i_sda;
    o_scl <= 1'b0;
    wt(4);
  endtask

  task automatic read_xfer(input logic [6:0] a, input int n,
      input logic ack_last, output logic ack, output logic [23:0] d);
    logic s;
    d = 24'h00_0000;
    wt(half);
    o_sda_rel <= 1'b0;
    wt(half);
    o_scl <= 1'b0;
    wt(4);
    for (int i = 6; i >= 0; i--) clk_bit(a[i], s);
    clk_bit(1'b1, s);
    clk_bit(1'b1, s);
    ack = ~s;
    for (int k = 0; k < n && ack; k++) begin
      for (int i = 7; i >= 0; i--) begin
        clk_bit(1'b1, s);
        d = {d[22:0], s};
      end
      clk_bit((k == n - 1) && !ack_last, s);
    end
    // Stop: data rises while clock high
    o_sda_rel <= 1'b0;
    wt(half);
    o_scl <= 1'b1;
    wt(half);
    o_sda_rel <= 1'b1;
    wt(half);
  endtask
endmodule

// ### power_monitor_readback_status_tb.sv
`timescale 1ns/1ps
// Readback block with a bus master model on its serial pins
module power_monitor_readback_status_tb
  import pm_pkg::*;
;
  logic         i_core_clk;
  logic         i_rst_n;
  logic [6:0]   addr;
  logic         trip;
  logic [4:0]   pls;
  pm_cmd_t      cmd;
  pm_alert_en_t en;
  logic [11:0]  volt;
  logic [11:0]  cur;
  logic [7:0]   th;
  logic         rel_val;
  logic         scl, sda_rel, sda_oe, sda_out, al_oe, al_out, once_p, clr_p;
  logic [7:0]   status;
  wire          sda_line;
  int           n_fail, tests_run;

  // Data line: pull-up unless someone pulls low
  assign sda_line = sda_rel & ~sda_oe;

  pm_readback dut_u (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(scl),
    .i_sda_in(sda_line), .i_dev_addr(addr), .i_trip_threshold_input(trip),
    .i_cmd_wr(pls[4]), .i_cmd(cmd), .i_conv_valid(pls[3]),
    .i_volt_code(volt), .i_cur_code(cur), .i_alert_en_wr(pls[1]),
    .i_alert_en(en), .i_thresh_wr(pls[2]), .i_thresh(th),
    .i_release_wr(pls[0]), .i_release_val(rel_val), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_alert_out(al_out), .o_alert_oe(al_oe),
    .o_once_pending(once_p), .o_clear_pending(clr_p), .o_status(status));

  pm_bus_master mst_u (.i_core_clk(i_core_clk), .i_sda(sda_line),
    .o_scl(scl), .o_sda_rel(sda_rel));

  ////////////////////////////////////////
  // Clock, 20 ns period
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // One cycle pulse on the selected write strobes
  task automatic pulse(input logic [4:0] p);
    @(posedge i_core_clk);
    pls <= p;
    @(posedge i_core_clk);
    pls <= 5'h00;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("TB: %0d checks, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Both channels, slow master clock
  task automatic t_both();
    logic a;
    logic [23:0] d;
    chk({al_oe, sda_oe, status}, 10'h000);
    cmd <= 5'h05;
    pulse(5'h10);
    volt <= 12'hA5C;
    cur <= 12'h3E1;
    pulse(5'h08);
    mst_u.half = 20;
    mst_u.read_xfer(addr, 3, 1'b0, a, d);
    mst_u.half = 8;
    chk({a, d}, 25'h1A5_3EC1);
  endtask

  // Voltage only: zeros first, wrong address, then data
  task automatic t_volt();
    logic a;
    logic [23:0] d;
    cmd <= 5'h01;
    pulse(5'h10);
    mst_u.read_xfer(addr, 2, 1'b0, a, d);
    chk({a, d[15:0]}, 17'h1_0000);
    volt <= 12'h9B7;
    cur <= 12'h123;
    pulse(5'h08);
    mst_u.read_xfer(addr ^ 7'h01, 2, 1'b0, a, d);
    chk(a, 1'b0);
    mst_u.read_xfer(addr, 2, 1'b0, a, d);
    chk({a, d}, 25'h100_9B70);
  endtask

  // Current once: refused until the conversion lands
  task automatic t_cur();
    logic a;
    logic [23:0] d;
    cmd <= 5'h08;
    pulse(5'h10);
    cyc(2);
    chk(once_p, 1'b1);
    mst_u.read_xfer(addr, 2, 1'b0, a, d);
    chk(a, 1'b0);
    cur <= 12'h5D2;
    pulse(5'h08);
    cyc(2);
    chk(once_p, 1'b0);
    mst_u.read_xfer(addr, 2, 1'b0, a, d);
    chk({a, d}, 25'h100_5D20);
  endtask

  // Status bits, alert pin, status read and clearing
  task automatic t_status();
    logic a;
    logic [23:0] d;
    th <= 8'h10;
    pulse(5'h04);
    trip <= 1'b1;
    cyc(8);
    chk({al_oe, status}, 9'h004);
    en <= 5'h0D;
    pulse(5'h02);
    cyc(2);
    chk({al_oe, status}, 9'h10C);
    cur <= 12'h200;
    repeat (4) pulse(5'h08);
    cyc(2);
    chk(status[1:0], 2'h3);
    rel_val <= 1'b1;
    pulse(5'h01);
    cyc(2);
    chk(status, 8'h3F);
    cmd <= 5'h10;
    pulse(5'h10);
    mst_u.read_xfer(addr, 1, 1'b1, a, d);
    chk({a, d}, 25'h100_003F);
    en <= 5'h1D;
    pulse(5'h02);
    cyc(3);
    chk(status[3], 1'b1);
    trip <= 1'b0;
    rel_val <= 1'b0;
    pulse(5'h01);
    cur <= 12'h001;
    pulse(5'h08);
    pulse(5'h02);
    cyc(4);
    chk({al_oe, status[5:1]}, 6'h00);
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    i_rst_n = 1'b0;
    addr = 7'h2A;
    trip = 1'b0;
    pls = 5'h00;
    cmd = 5'h00;
    en = 5'h00;
    volt = 12'h000;
    cur = 12'h000;
    th = 8'h00;
    rel_val = 1'b0;
    cyc(12);
    i_rst_n <= 1'b1;
    cyc(4);
    t_both();
    t_volt();
    t_cur();
    t_status();
    report_and_stop();
  end

  // Watchdog, well beyond the expected run
  initial begin
    cyc(60000);
    n_fail++;
    report_and_stop();
  end
endmodule
